// >>> rcc_pkg.sv
// Purpose: Shared constants for reset combining and clock source control
// Assumes: 20 MHz control clock, 32-bit register bus with byte addresses
// Notes: Offsets are byte addresses, one aligned word per register
package rcc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int RESET_PULSE_NS = 500;
	localparam int RESET_PULSE_CYCLES =
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWITCH_GAP_NS = 200;
	localparam int SWITCH_GAP_CYCLES =
		(SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_POR_BOR_CTRL = 8'h00;
	localparam logic [7:0] OFS_RESET_CAUSE = 8'h04;
	localparam logic [7:0] OFS_PERIPH_RST0 = 8'h08;
	localparam logic [7:0] OFS_PERIPH_RST1 = 8'h0C;
	localparam logic [7:0] OFS_PERIPH_RST2 = 8'h10;
	localparam logic [7:0] OFS_WDT_LOAD = 8'h14;
	localparam logic [7:0] OFS_WDT_CTRL = 8'h18;
	localparam logic [7:0] OFS_WDT_VALUE = 8'h1C;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h20;
	localparam logic [7:0] OFS_REGULATOR_CTRL = 8'h24;
	localparam logic [7:0] OFS_CLOCK_CFG = 8'h28;
	localparam logic [7:0] OFS_CLOCK_STATUS = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_BOR_DETECT_EN = 0;
	localparam int BIT_BOR_RESET_EN = 1;
	localparam int CAUSE_EXT = 0;
	localparam int CAUSE_POR = 1;
	localparam int CAUSE_BOR = 2;
	localparam int CAUSE_SW = 3;
	localparam int CAUSE_WDT = 4;
	localparam int BIT_WDT_ENABLE = 0;
	localparam int BIT_WDT_RESET_EN = 1;
	localparam int BIT_FLAG_WDT = 0;
	localparam int BIT_FLAG_BOR = 1;
	localparam int POS_OSC_SRC = 0;
	localparam int POS_PLL_SKIP = 2;
	localparam int POS_OSC_SRC_EXT = 4;
	localparam int POS_BUSY = 4;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [4:0] CAUSE_AFTER_POR = 5'h02;
	localparam int TRIM_W = 6;
	localparam int TRIM_MIN_MV = 2250;
	localparam int TRIM_MAX_MV = 2750;
	localparam int TRIM_STEP_MV = 50;
	localparam logic [TRIM_W-1:0] TRIM_MAX_CODE =
		TRIM_W'((TRIM_MAX_MV - TRIM_MIN_MV) / TRIM_STEP_MV);
	localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h05;
	localparam logic [1:0] OSC_MAIN = 2'h0;
	localparam logic [1:0] OSC_INTERNAL = 2'h1;
	localparam logic [1:0] OSC_INT_DIV4 = 2'h2;
	localparam logic [1:0] OSC_LF30K = 2'h3;
	localparam logic [2:0] OSC_EXT_RTC = 3'h7;
	localparam logic [2:0] OSC_EXT_NONE = 3'h0;

	// Selected system clock source, one enable line each
	localparam int NUM_SRC = 6;
	localparam logic [2:0] SRC_MAIN = 3'h0;
	localparam logic [2:0] SRC_INTERNAL = 3'h1;
	localparam logic [2:0] SRC_INT_DIV4 = 3'h2;
	localparam logic [2:0] SRC_LF30K = 3'h3;
	localparam logic [2:0] SRC_RTC = 3'h4;
	localparam logic [2:0] SRC_PLL = 3'h5;

	typedef enum logic [2:0] {
		FETCH_HOLD,
		FETCH_STACK,
		FETCH_PC,
		FETCH_INSTR,
		FETCH_RUN
	} fetch_t;

endpackage : rcc_pkg

// >>> clk_switch_if.sv
// Purpose: Carries clock source requests to the glitch-free switcher
// Assumes: Both ends on the control clock
// Notes: Request is a level; the switcher follows it
`timescale 1ns/1ns
interface clk_switch_if;
	logic [2:0] reqSource;
	logic busy;
	logic [2:0] activeSource;

	modport ctrl (output reqSource, input busy, input activeSource);
	modport sw (input reqSource, output busy, output activeSource);
endinterface : clk_switch_if

// >>> clock_switch.sv
// Purpose: Break-before-make sequencing of system clock source enables
// Assumes: Enables gate the oscillators into a glitch-free clock mux
// Notes: All enables stay low for a gap before the new one rises
`timescale 1ns/1ns
module clock_switch (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clkEn,
	clk_switch_if.sw swIf,
	output logic [rcc_pkg::NUM_SRC-1:0] srcEnable
);
	import rcc_pkg::*;

	typedef enum logic {SW_RUN, SW_GAP} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [2:0] cur;
		logic [7:0] gap;
		logic [NUM_SRC-1:0] en;
	} sw_state_t;

	sw_state_t s_reg;
	sw_state_t s_next;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		case (s_reg.phase)
			SW_RUN: begin
				if (swIf.reqSource != s_reg.cur) begin
					s_next.phase = SW_GAP;
					s_next.en = '0;
					s_next.gap = 8'(SWITCH_GAP_CYCLES);
				end
			end
			SW_GAP: begin
				// Target taken at gap end, so late changes are honoured
				if (s_reg.gap == 8'h00) begin
					s_next.phase = SW_RUN;
					s_next.cur = swIf.reqSource;
					s_next.en = NUM_SRC'(1) << swIf.reqSource;
				end else begin
					s_next.gap = s_reg.gap - 8'h01;
				end
			end
			default: s_next.phase = SW_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '{SW_RUN, SRC_INTERNAL, 8'h00,
				NUM_SRC'(1) << SRC_INTERNAL};
		end else if (clkEn) begin
			s_reg <= s_next;
		end
	end

	assign srcEnable = s_reg.en;
	assign swIf.busy = (s_reg.phase == SW_GAP);
	assign swIf.activeSource = s_reg.cur;

endmodule : clock_switch

// >>> reset_clock_control.sv
// Purpose: Combines reset sources, runs watchdog, selects clock source
// Assumes: arst_n is the power-on reset; register bus is Avalon-MM
// Notes: Internal reset is released through a register on clk
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module reset_clock_control (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	input wire logic extReset_n,
	input wire logic brownoutDetect,
	input wire logic systemResetRequest,
	input wire logic fetchDone,
	output logic coreReset_n,
	output logic tapReset_n,
	output rcc_pkg::fetch_t fetchStep,
	output logic [2:0][31:0] periphReset,
	output logic watchdogIrq,
	output logic brownoutIrq,
	output logic [rcc_pkg::TRIM_W-1:0] regulatorVoltageTrim,
	output logic [rcc_pkg::NUM_SRC-1:0] srcEnable
);
	import rcc_pkg::*;

	typedef struct packed {
		logic [1:0] extSync;
		logic [1:0] borSync;
		logic borDetectEn;
		logic brownoutResetEnable;
		logic [4:0] cause;
		logic [2:0][31:0] periph;
		logic [2:0][31:0] periphOut;
		logic [31:0] watchdog_reload_value;
		logic [31:0] wdtCount;
		logic wdtEnable;
		logic wdtResetEn;
		logic wdtFlag;
		logic borFlag;
		logic [TRIM_W-1:0] trim;
		logic [1:0] oscSourceSelect;
		logic [2:0] oscSourceSelectExt;
		logic pllSkipSelect;
		logic [2:0] reqSource;
		logic [7:0] rstCount;
		logic intReset;
		fetch_t fetch;
		logic ack;
		logic [31:0] rdata;
		logic tapRelease;
	} state_t;

	state_t s_reg;
	state_t s_next;
	clk_switch_if swIf ();

	logic busReq;
	logic doWrite;
	logic borSeen;
	logic borReset;
	logic wdtReset;
	logic anySource;
	logic [2:0] cfgSource;
	logic cfgValid;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] mergeBe(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction : mergeBe

	function automatic logic [31:0] readMux(input state_t st,
		input logic [7:0] a, input logic busy, input logic [2:0] act);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OFS_POR_BOR_CTRL: begin
				r[BIT_BOR_DETECT_EN] = st.borDetectEn;
				r[BIT_BOR_RESET_EN] = st.brownoutResetEnable;
			end
			OFS_RESET_CAUSE: r[4:0] = st.cause;
			OFS_PERIPH_RST0: r = st.periph[0];
			OFS_PERIPH_RST1: r = st.periph[1];
			OFS_PERIPH_RST2: r = st.periph[2];
			OFS_WDT_LOAD: r = st.watchdog_reload_value;
			OFS_WDT_CTRL: begin
				r[BIT_WDT_ENABLE] = st.wdtEnable;
				r[BIT_WDT_RESET_EN] = st.wdtResetEn;
			end
			OFS_WDT_VALUE: r = st.wdtCount;
			OFS_EVENT_FLAGS: begin
				r[BIT_FLAG_WDT] = st.wdtFlag;
				r[BIT_FLAG_BOR] = st.borFlag;
			end
			OFS_REGULATOR_CTRL: r[TRIM_W-1:0] = st.trim;
			OFS_CLOCK_CFG: begin
				r[POS_OSC_SRC +: 2] = st.oscSourceSelect;
				r[POS_PLL_SKIP] = st.pllSkipSelect;
				r[POS_OSC_SRC_EXT +: 3] = st.oscSourceSelectExt;
			end
			OFS_CLOCK_STATUS: begin
				r[2:0] = act;
				r[POS_BUSY] = busy;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : readMux

	// ----------------------------------------------------------------
	// Clock source decode
	// ----------------------------------------------------------------
	always_comb begin
		cfgValid = 1'b1;
		cfgSource = SRC_INTERNAL;
		if (s_reg.pllSkipSelect &&
			s_reg.oscSourceSelectExt == OSC_EXT_RTC) begin
			cfgSource = SRC_RTC;
		end else if (s_reg.pllSkipSelect) begin
			case (s_reg.oscSourceSelect)
				OSC_MAIN: cfgSource = SRC_MAIN;
				OSC_INTERNAL: cfgSource = SRC_INTERNAL;
				OSC_INT_DIV4: cfgSource = SRC_INT_DIV4;
				OSC_LF30K: cfgSource = SRC_LF30K;
				default: cfgSource = SRC_INTERNAL;
			endcase
		end else if (s_reg.oscSourceSelect == OSC_MAIN) begin
			// PLL fed by main oscillator only
			cfgSource = SRC_PLL;
		end else begin
			cfgValid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.extSync = {s_reg.extSync[0], extReset_n};
		s_next.borSync = {s_reg.borSync[0], brownoutDetect};
		s_next.tapRelease = 1'b1;
		busReq = avsRead | avsWrite;
		doWrite = avsWrite & s_reg.ack;
		wdtReset = 1'b0;

		// One wait state; read data captured while waitrequest is high
		s_next.ack = busReq & !s_reg.ack;
		if (busReq && !s_reg.ack) begin
			s_next.rdata = avsRead ? readMux(s_reg, avsAddress,
				swIf.busy, swIf.activeSource) : 32'h0000_0000;
		end

		if (doWrite) begin
			case (avsAddress)
				OFS_POR_BOR_CTRL: begin
					if (avsByteenable[0]) begin
						s_next.borDetectEn = avsWritedata[BIT_BOR_DETECT_EN];
						s_next.brownoutResetEnable =
							avsWritedata[BIT_BOR_RESET_EN];
					end
				end
				OFS_RESET_CAUSE: begin
					// Write one to clear
					if (avsByteenable[0]) begin
						s_next.cause = s_reg.cause & ~avsWritedata[4:0];
					end
				end
				OFS_PERIPH_RST0: s_next.periph[0] =
					mergeBe(s_reg.periph[0], avsWritedata, avsByteenable);
				OFS_PERIPH_RST1: s_next.periph[1] =
					mergeBe(s_reg.periph[1], avsWritedata, avsByteenable);
				OFS_PERIPH_RST2: s_next.periph[2] =
					mergeBe(s_reg.periph[2], avsWritedata, avsByteenable);
				OFS_WDT_LOAD: begin
					s_next.watchdog_reload_value =
						mergeBe(s_reg.watchdog_reload_value, avsWritedata, avsByteenable);
					s_next.wdtCount = s_next.watchdog_reload_value;
				end
				OFS_WDT_CTRL: begin
					if (avsByteenable[0]) begin
						s_next.wdtEnable = avsWritedata[BIT_WDT_ENABLE];
						s_next.wdtResetEn = avsWritedata[BIT_WDT_RESET_EN];
					end
				end
				OFS_EVENT_FLAGS: begin
					if (avsByteenable[0]) begin
						s_next.wdtFlag = s_reg.wdtFlag &
							!avsWritedata[BIT_FLAG_WDT];
						s_next.borFlag = s_reg.borFlag &
							!avsWritedata[BIT_FLAG_BOR];
					end
				end
				OFS_REGULATOR_CTRL: begin
					// clamp to the top of the range
					if (avsByteenable[0]) begin
						s_next.trim = (avsWritedata[TRIM_W-1:0] > TRIM_MAX_CODE)
							? TRIM_MAX_CODE : avsWritedata[TRIM_W-1:0];
					end
				end
				OFS_CLOCK_CFG: begin
					if (avsByteenable[0]) begin
						s_next.oscSourceSelect = avsWritedata[POS_OSC_SRC +: 2];
						s_next.pllSkipSelect = avsWritedata[POS_PLL_SKIP];
						s_next.oscSourceSelectExt =
							avsWritedata[POS_OSC_SRC_EXT +: 3];
					end
				end
				default: s_next.ack = 1'b0;
			endcase
		end

		// Invalid combinations keep the previous source running
		if (cfgValid) begin
			s_next.reqSource = cfgSource;
		end

		// Brown-out; flag set below so it wins over a clear
		// only with detection enabled
		borSeen = s_reg.borSync[1] & s_reg.borDetectEn;
		borReset = borSeen & s_reg.brownoutResetEnable;
		if (borSeen && !s_reg.brownoutResetEnable) begin
			s_next.borFlag = 1'b1;
		end

		// Watchdog
		if (s_reg.wdtEnable && !s_reg.intReset) begin
			if (s_reg.wdtCount == 32'h0000_0000) begin
				s_next.wdtCount = s_reg.watchdog_reload_value;
				if (!s_reg.wdtFlag) begin
					s_next.wdtFlag = 1'b1;
				end else if (s_reg.wdtResetEn) begin
					wdtReset = 1'b1;
				end
			end else begin
				s_next.wdtCount = s_reg.wdtCount - 32'h0000_0001;
			end
		end

		// Reset combining; level sources hold, pulses are stretched
		// brown-out held like the pin
		anySource = !s_reg.extSync[1] | borReset | wdtReset |
			systemResetRequest;
		if (anySource) begin
			s_next.intReset = 1'b1;
			s_next.rstCount = 8'(RESET_PULSE_CYCLES);
		end else if (s_reg.rstCount != 8'h00) begin
			s_next.rstCount = s_reg.rstCount - 8'h01;
		end else begin
			s_next.intReset = 1'b0;
		end
		if (!s_reg.extSync[1]) begin
			s_next.cause[CAUSE_EXT] = 1'b1;
		end
		if (borReset) begin
			s_next.cause[CAUSE_BOR] = 1'b1;
		end
		if (wdtReset) begin
			s_next.cause[CAUSE_WDT] = 1'b1;
		end
		if (systemResetRequest) begin
			s_next.cause[CAUSE_SW] = 1'b1;
		end

		// Internal reset returns control state; cause, trim, WDT load, BOR enables and bus survive
		if (s_next.intReset) begin
			s_next.periph = '0;
			s_next.wdtEnable = 1'b0;
			s_next.wdtResetEn = 1'b0;
			s_next.wdtFlag = 1'b0;
			s_next.wdtCount = 32'h0000_0000;
			s_next.borFlag = 1'b0;
			s_next.oscSourceSelect = OSC_INTERNAL;
			s_next.pllSkipSelect = 1'b1;
			s_next.oscSourceSelectExt = OSC_EXT_NONE;
			s_next.reqSource = SRC_INTERNAL;
		end

		// every line of the unit, plus system reset
		for (int k = 0; k < 3; k++) begin
			s_next.periphOut[k] = s_next.periph[k] | {32{s_next.intReset}};
		end

		case (s_reg.fetch)
			FETCH_HOLD: s_next.fetch = FETCH_STACK;
			FETCH_STACK: if (fetchDone) s_next.fetch = FETCH_PC;
			FETCH_PC: if (fetchDone) s_next.fetch = FETCH_INSTR;
			FETCH_INSTR: if (fetchDone) s_next.fetch = FETCH_RUN;
			FETCH_RUN: s_next.fetch = FETCH_RUN;
			default: s_next.fetch = FETCH_HOLD;
		endcase
		if (s_next.intReset) begin
			s_next.fetch = FETCH_HOLD;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.extSync <= 2'b11;
			// power-on keeps only its own bit
			s_reg.cause <= CAUSE_AFTER_POR;
			s_reg.periphOut <= '1;
			s_reg.trim <= TRIM_RESET;
			s_reg.oscSourceSelect <= OSC_INTERNAL;
			s_reg.pllSkipSelect <= 1'b1;
			s_reg.reqSource <= SRC_INTERNAL;
			s_reg.rstCount <= 8'(RESET_PULSE_CYCLES);
			s_reg.intReset <= 1'b1;
			s_reg.fetch <= FETCH_HOLD;
		end else if (clkEn) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Clock switch
	// ----------------------------------------------------------------
	assign swIf.reqSource = s_reg.reqSource;

	clock_switch u_switch (
		.clk(clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.swIf(swIf.sw),
		.srcEnable(srcEnable)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign avsWaitrequest = busReq & !s_reg.ack;
	assign avsReaddata = s_reg.rdata;
	assign coreReset_n = !s_reg.intReset;
	// only power-on resets the test controller
	assign tapReset_n = s_reg.tapRelease;
	assign fetchStep = s_reg.fetch;
	assign periphReset = s_reg.periphOut;
	assign watchdogIrq = s_reg.wdtFlag;
	assign brownoutIrq = s_reg.borFlag;
	assign regulatorVoltageTrim = s_reg.trim;

endmodule : reset_clock_control

// >>> reset_clock_control_checker.sv
// Purpose: Concurrent checks on the reset and clock control ports
// Assumes: Single clock domain, arst_n is the power-on reset
// Notes: Bound to every reset_clock_control instance
`timescale 1ns/1ns
module reset_clock_control_checker
	import rcc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic systemResetRequest,
	input wire logic fetchDone,
	input wire logic coreReset_n,
	input wire logic tapReset_n,
	input wire rcc_pkg::fetch_t fetchStep,
	input wire logic [2:0][31:0] periphReset,
	input wire logic [rcc_pkg::TRIM_W-1:0] regulatorVoltageTrim,
	input wire logic [rcc_pkg::NUM_SRC-1:0] srcEnable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_swRst;
		clkEn && systemResetRequest |=> !coreReset_n;
	endproperty
	a_swRst: assert property (p_swRst) else $error("no system reset");
	property p_stretch;
		$rose(coreReset_n) |-> $past(coreReset_n, 10) == 1'h0;
	endproperty
	a_stretch: assert property (p_stretch) else $error("short reset");
	property p_fetchStart;
		$rose(coreReset_n) |=> fetchStep == FETCH_STACK;
	endproperty
	a_fetchStart: assert property (p_fetchStart) else $error("no fetch");
	property p_hold;
		!coreReset_n |-> fetchStep == FETCH_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("fetch in reset");
	property p_order;
		clkEn && coreReset_n && fetchDone && fetchStep == FETCH_PC
			|=> fetchStep == FETCH_INSTR || !coreReset_n;
	endproperty
	a_order: assert property (p_order) else $error("fetch order");
	property p_periph;
		!coreReset_n |-> &periphReset;
	endproperty
	a_periph: assert property (p_periph) else $error("unit not reset");
	property p_tap;
		$fell(coreReset_n) |-> tapReset_n;
	endproperty
	a_tap: assert property (p_tap) else $error("test ctrl reset");
	property p_trim;
		regulatorVoltageTrim <= 6'h0A;
	endproperty
	a_trim: assert property (p_trim) else $error("trim range");
	property p_bmb;
		$past(srcEnable) != 6'h00 && srcEnable != 6'h00
			|-> srcEnable == $past(srcEnable);
	endproperty
	a_bmb: assert property (p_bmb) else $error("direct switch");
	property p_gap;
		$past(srcEnable) != 6'h00 && srcEnable == 6'h00
			|-> (srcEnable == 6'h00)[*4];
	endproperty
	a_gap: assert property (p_gap) else $error("gap too short");
	property p_src;
		$rose(coreReset_n) |-> srcEnable == 6'h02;
	endproperty
	a_src: assert property (p_src) else $error("not internal osc");
endmodule : reset_clock_control_checker

bind reset_clock_control reset_clock_control_checker u_chk (.*);

// >>> reset_clock_control_tb.sv
// Purpose: Self-checking bench for reset_clock_control
// Assumes: clkEn held high except for the watchdog freeze, all byte lanes enabled
// Notes: Cause bits accumulate on purpose across scenarios
`timescale 1ns/1ns
module reset_clock_control_tb;
	import rcc_pkg::*;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic clkEn = 1'h1;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'h0;
	logic avsWrite = 1'h0;
	logic [31:0] avsWritedata = 32'h0;
	logic [3:0] avsByteenable = 4'hF;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic extReset_n = 1'h1;
	logic brownoutDetect = 1'h0;
	logic systemResetRequest = 1'h0;
	logic fetchDone = 1'h0;
	logic coreReset_n;
	logic tapReset_n;
	fetch_t fetchStep;
	logic [2:0][31:0] periphReset;
	logic watchdogIrq;
	logic brownoutIrq;
	logic [TRIM_W-1:0] regulatorVoltageTrim;
	logic [NUM_SRC-1:0] srcEnable;
	logic [7:0] cfgTab [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h74, 8'h00,
		8'h01};
	logic [2:0] srcTab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
	logic [31:0] rdat;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int i;
	int j;

	reset_clock_control u_dut (.*);

	always #25 clk = ~clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		do @(posedge clk); while (avsWaitrequest !== 1'h0);
		rdat = avsReaddata;
		avsWrite <= 1'h0;
		avsRead <= 1'h0;
	endtask : bus

	task waitRel;
		for (j = 0; j < 80 && coreReset_n !== 1'h1; j++) @(posedge clk);
		chk({31'h0, coreReset_n}, 32'h1);
	endtask : waitRel

	task causeIs(input logic [31:0] exp);
		bus(1'h0, OFS_RESET_CAUSE, 32'h0);
		chk(rdat, exp);
	endtask : causeIs

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_power;
		waitRel;
		causeIs(32'h02);
		bus(1'h0, OFS_POR_BOR_CTRL, 32'h0);
		chk(rdat, 32'h0);
		bus(1'h0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
		bus(1'h0, OFS_CLOCK_STATUS, 32'h0);
		chk(rdat, 32'h1);
		$display("power-on test done");
	endtask : t_power

	task t_brownout;
		brownoutDetect <= 1'h1;
		repeat (6) @(posedge clk);
		chk({31'h0, brownoutIrq}, 32'h0);
		bus(1'h1, OFS_POR_BOR_CTRL, 32'h1);
		repeat (6) @(posedge clk);
		chk({30'h0, brownoutIrq, coreReset_n}, 32'h3);
		bus(1'h1, OFS_POR_BOR_CTRL, 32'h3);
		repeat (30) @(posedge clk);
		chk({31'h0, coreReset_n}, 32'h0);
		brownoutDetect <= 1'h0;
		waitRel;
		causeIs(32'h06);
		$display("brown-out test done");
	endtask : t_brownout

	task t_periph;
		for (i = 0; i < 3; i++) begin
			bus(1'h1, OFS_PERIPH_RST0 + 8'(4 * i), 32'h1 << (5 * i + 1));
			@(posedge clk);
			chk(periphReset[i], 32'h1 << (5 * i + 1));
			bus(1'h1, OFS_PERIPH_RST0 + 8'(4 * i), 32'h0);
			@(posedge clk);
			chk(periphReset[i], 32'h0);
		end
		$display("peripheral reset test done");
	endtask : t_periph

	task t_sysreset;
		systemResetRequest <= 1'h1;
		@(posedge clk);
		systemResetRequest <= 1'h0;
		@(posedge clk);
		chk({31'h0, coreReset_n}, 32'h0);
		waitRel;
		@(posedge clk);
		for (i = 0; i < 3; i++) begin
			chk(32'(fetchStep), 32'(FETCH_STACK) + i);
			fetchDone <= 1'h1;
			@(posedge clk);
			fetchDone <= 1'h0;
			@(posedge clk);
		end
		chk(32'(fetchStep), 32'(FETCH_RUN));
		causeIs(32'h0E);
		$display("system reset test done");
	endtask : t_sysreset

	task t_watchdog;
		bus(1'h1, OFS_WDT_LOAD, 32'h5);
		bus(1'h1, OFS_WDT_CTRL, 32'h1);
		for (i = 0; i < 20 && watchdogIrq !== 1'h1; i++) @(posedge clk);
		chk({31'h0, watchdogIrq}, 32'h1);
		repeat (20) @(posedge clk);
		chk({31'h0, coreReset_n}, 32'h1);
		// Stop, then clear the flag: next zero is a first timeout
		bus(1'h1, OFS_WDT_CTRL, 32'h0);
		bus(1'h1, OFS_EVENT_FLAGS, 32'h1);
		@(posedge clk);
		chk({31'h0, watchdogIrq}, 32'h0);
		bus(1'h1, OFS_WDT_CTRL, 32'h3);
		for (i = 0; i < 20 && watchdogIrq !== 1'h1; i++) @(posedge clk);
		chk({30'h0, watchdogIrq, coreReset_n}, 32'h3);
		// Frozen counter must not reach its second timeout
		clkEn <= 1'h0;
		repeat (20) @(posedge clk);
		chk({31'h0, coreReset_n}, 32'h1);
		clkEn <= 1'h1;
		for (i = 0; i < 12 && coreReset_n !== 1'h0; i++) @(posedge clk);
		chk({31'h0, coreReset_n}, 32'h0);
		waitRel;
		causeIs(32'h1E);
		$display("watchdog test done");
	endtask : t_watchdog

	task t_extpin;
		extReset_n <= 1'h0;
		repeat (5) @(posedge clk);
		chk({30'h0, tapReset_n, coreReset_n}, 32'h2);
		extReset_n <= 1'h1;
		waitRel;
		causeIs(32'h1F);
		// Write one to clear all but the power-on bit
		bus(1'h1, OFS_RESET_CAUSE, 32'h1D);
		causeIs(32'h02);
		$display("reset pin test done");
	endtask : t_extpin

	task t_trim;
		bus(1'h1, OFS_REGULATOR_CTRL, 32'h3F);
		bus(1'h0, OFS_REGULATOR_CTRL, 32'h0);
		chk(rdat, 32'h0A);
		bus(1'h1, OFS_REGULATOR_CTRL, 32'h0);
		@(posedge clk);
		chk(32'(regulatorVoltageTrim), 32'h0);
		$display("trim test done");
	endtask : t_trim

	// Last row is an illegal setting, source must stay
	task t_clock;
		for (i = 0; i < 7; i++) begin
			bus(1'h1, OFS_CLOCK_CFG, 32'(cfgTab[i]));
			for (j = 0; j < 20 && srcEnable !== 6'h01 << srcTab[i]; j++)
				@(posedge clk);
			bus(1'h0, OFS_CLOCK_STATUS, 32'h0);
			chk(32'(srcEnable), 32'h1 << srcTab[i]);
			chk(rdat, 32'(srcTab[i]));
		end
		$display("clock select test done");
	endtask : t_clock

	// ----------------------------------------------------------------
	// Sequence and timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'h1;
		t_power();
		t_brownout();
		t_periph();
		t_sysreset();
		t_watchdog();
		t_extpin();
		t_trim();
		t_clock();
		final_report();
	end
endmodule : reset_clock_control_tb
